// ### src/drive_power_state_control.sv
// Power state machine, command and state words and speed objects of a drive
`timescale 1ns/1ns
module drive_power_state_control #(
  parameter logic [31:0] DEVICE_ID      = 32'h0000A5A5, // Arbitrary value
  parameter logic [31:0] BOOT_VERSION   = 32'h00000000,
  parameter logic [31:0] BOOT_BUS_MASK  = 32'h00000000,
  parameter logic [31:0] BOOT_HW_GROUP  = 32'h00000000
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire drive_pkg::obj_req_t obj_req,
  output drive_pkg::obj_resp_t     obj_resp,
  input  wire drive_pkg::sense_t   sense_raw,
  input  wire logic [7:0]          op_mode,
  input  wire logic [1:0]          mode_status,
  input  wire logic [31:0]         error_history_entry,
  output logic                     power_stage_on,
  output logic                     run_enabled,
  output logic                     quick_stop_ramp,
  output logic                     pause_motion,
  output logic [3:0]               mode_specific_bits,
  output logic [15:0]              speed_demand,
  output logic [15:0]              drive_status
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  drive_pkg::sense_t       sense;
  drive_pkg::drive_state_t state_ff;
  drive_pkg::drive_state_t nxt_state;
  drive_pkg::obj_resp_t    resp_ff;
  drive_pkg::obj_resp_t    nxt_resp;

  logic [15:0] command_ff;
  logic [15:0] nxt_command;
  logic [15:0] speed_req_ff;
  logic [15:0] nxt_speed_req;
  logic [31:0] speed_min_ff;
  logic [31:0] nxt_speed_min;
  logic [31:0] speed_max_ff;
  logic [31:0] nxt_speed_max;

  logic        clear_prev_ff;
  logic        warn_ff;
  logic        nxt_warn;
  logic        clear_edge;

  logic [15:0] status_ff;
  logic [15:0] nxt_status;
  logic [15:0] error_ff;
  logic        power_ff;
  logic        nxt_power;
  logic        run_ff;
  logic        nxt_run;
  logic        qs_ramp_ff;
  logic        nxt_qs_ramp;
  logic        pause_ff;
  logic        nxt_pause;
  logic [3:0]  mode_bits_ff;
  logic [15:0] demand_ff;
  logic [15:0] nxt_demand;

  logic [15:0] bounded;
  logic        limited;
  logic        pause_mode;

  logic        c_switch;
  logic        c_power;
  logic        c_qs;
  logic        c_run;

  ////////////////////////////////////////////////////////////////////////////////
  // Outside inputs and speed clamp
  sense_sync #(
    .W ($bits(drive_pkg::sense_t))
  ) u_sense_sync (
    .clk   (clk),
    .reset (reset),
    .raw   (sense_raw),
    .clean (sense)
  );

  speed_limiter u_speed_limiter (
    .requested  (speed_req_ff),
    .min_amount (speed_min_ff),
    .max_amount (speed_max_ff),
    .bounded    (bounded),
    .limited    (limited)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Object access
  always_comb begin
    nxt_command   = command_ff;
    nxt_speed_req = speed_req_ff;
    nxt_speed_min = speed_min_ff;
    nxt_speed_max = speed_max_ff;
    nxt_resp      = '0;
    if (obj_req.valid) begin
      nxt_resp.valid = 1'b1;
      nxt_resp.abort = 1'b1;
      case (obj_req.index)
        drive_pkg::IDX_DEVICE_ID: begin
          if (!obj_req.write && obj_req.sub == drive_pkg::SUB_COUNT) begin
            nxt_resp.abort = 1'b0;
            nxt_resp.rdata = DEVICE_ID;
          end
        end
        drive_pkg::IDX_BOOT_INFO: begin
          if (!obj_req.write) begin
            nxt_resp.abort = 1'b0;
            case (obj_req.sub)
              drive_pkg::SUB_COUNT:    nxt_resp.rdata = drive_pkg::BOOT_ENTRIES;
              drive_pkg::SUB_BOOT_VER: nxt_resp.rdata = BOOT_VERSION;
              drive_pkg::SUB_BOOT_BUS: nxt_resp.rdata = BOOT_BUS_MASK;
              drive_pkg::SUB_BOOT_HW:  nxt_resp.rdata = BOOT_HW_GROUP;
              default:                 nxt_resp.abort = 1'b1;
            endcase
          end
        end
        drive_pkg::IDX_LAST_ERROR: begin
          if (!obj_req.write && obj_req.sub == drive_pkg::SUB_COUNT) begin
            nxt_resp.abort = 1'b0;
            nxt_resp.rdata = {16'h0000, error_ff};
          end
        end
        drive_pkg::IDX_COMMAND: begin
          if (obj_req.sub == drive_pkg::SUB_COUNT) begin
            nxt_resp.abort = 1'b0;
            nxt_resp.rdata = {16'h0000, command_ff};
            if (obj_req.write) begin
              nxt_command = obj_req.wdata[15:0];
            end
          end
        end
        drive_pkg::IDX_STATE_WORD: begin
          if (!obj_req.write && obj_req.sub == drive_pkg::SUB_COUNT) begin
            nxt_resp.abort = 1'b0;
            nxt_resp.rdata = {16'h0000, status_ff};
          end
        end
        drive_pkg::IDX_SPEED: begin
          if (obj_req.sub == drive_pkg::SUB_COUNT) begin
            nxt_resp.abort = 1'b0;
            nxt_resp.rdata = {{16{speed_req_ff[15]}}, speed_req_ff};
            if (obj_req.write) begin
              nxt_speed_req = obj_req.wdata[15:0];
            end
          end
        end
        drive_pkg::IDX_SPEED_LIM: begin
          nxt_resp.abort = 1'b0;
          case (obj_req.sub)
            drive_pkg::SUB_COUNT: begin
              nxt_resp.rdata = drive_pkg::LIM_ENTRIES;
              nxt_resp.abort = obj_req.write;
            end
            drive_pkg::SUB_SPEED_MIN: begin
              nxt_resp.rdata = speed_min_ff;
              if (obj_req.write) begin
                nxt_speed_min = obj_req.wdata;
              end
            end
            drive_pkg::SUB_SPEED_MAX: begin
              nxt_resp.rdata = speed_max_ff;
              if (obj_req.write) begin
                nxt_speed_max = obj_req.wdata;
              end
            end
            default: nxt_resp.abort = 1'b1;
          endcase
        end
        default: nxt_resp.abort = 1'b1;
      endcase
      if (nxt_resp.abort) begin
        nxt_resp.rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      command_ff   <= drive_pkg::COMMAND_RESET;
      speed_req_ff <= drive_pkg::SPEED_RESET;
      speed_min_ff <= drive_pkg::SPEED_MIN_RST;
      speed_max_ff <= drive_pkg::SPEED_MAX_RST;
      resp_ff      <= '0;
    end else begin
      command_ff   <= nxt_command;
      speed_req_ff <= nxt_speed_req;
      speed_min_ff <= nxt_speed_min;
      speed_max_ff <= nxt_speed_max;
      resp_ff      <= nxt_resp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power state machine
  assign c_switch   = command_ff[drive_pkg::CMD_SWITCH_ON];
  assign c_power    = command_ff[drive_pkg::CMD_POWER];
  assign c_qs       = command_ff[drive_pkg::CMD_QUICK_STOP];
  assign c_run      = command_ff[drive_pkg::CMD_RUN];
  assign clear_edge = command_ff[drive_pkg::CMD_FAULT_CLEAR] & ~clear_prev_ff;

  always_comb begin
    nxt_state = state_ff;
    // A warning that arrives with the clear edge stays latched
    nxt_warn  = sense.warning | (warn_ff & ~clear_edge);
    case (state_ff)
      drive_pkg::S_NOT_READY: begin
        nxt_state = drive_pkg::S_INHIBITED;
      end
      drive_pkg::S_INHIBITED: begin
        if (c_power && c_qs && !c_switch) begin
          nxt_state = drive_pkg::S_READY;
        end
      end
      drive_pkg::S_READY: begin
        if (!c_power || !c_qs) begin
          nxt_state = drive_pkg::S_INHIBITED;
        end else if (c_switch && c_run) begin
          nxt_state = drive_pkg::S_RUNNING;
        end else if (c_switch) begin
          nxt_state = drive_pkg::S_SWITCHED_ON;
        end
      end
      drive_pkg::S_SWITCHED_ON: begin
        if (!c_power || !c_qs) begin
          nxt_state = drive_pkg::S_INHIBITED;
        end else if (!c_switch) begin
          nxt_state = drive_pkg::S_READY;
        end else if (c_run) begin
          nxt_state = drive_pkg::S_RUNNING;
        end
      end
      drive_pkg::S_RUNNING: begin
        if (!c_power) begin
          nxt_state = drive_pkg::S_INHIBITED;
        end else if (!c_qs) begin
          nxt_state = drive_pkg::S_QUICK_STOP;
        end else if (!c_switch) begin
          nxt_state = drive_pkg::S_READY;
        end else if (!c_run) begin
          nxt_state = drive_pkg::S_SWITCHED_ON;
        end
      end
      drive_pkg::S_QUICK_STOP: begin
        if (!c_power || sense.standstill) begin
          nxt_state = drive_pkg::S_INHIBITED;
        end
      end
      drive_pkg::S_FAULT_REACT: begin
        if (sense.standstill) begin
          nxt_state = drive_pkg::S_FAULT;
        end
      end
      drive_pkg::S_FAULT: begin
        if (clear_edge && !sense.fault) begin
          nxt_state = drive_pkg::S_INHIBITED;
        end
      end
      default: nxt_state = drive_pkg::S_NOT_READY;
    endcase
    if (sense.fault && state_ff != drive_pkg::S_FAULT_REACT
        && state_ff != drive_pkg::S_FAULT) begin
      nxt_state = drive_pkg::S_FAULT_REACT;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff      <= drive_pkg::S_NOT_READY;
      clear_prev_ff <= 1'b0;
      warn_ff       <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      clear_prev_ff <= command_ff[drive_pkg::CMD_FAULT_CLEAR];
      warn_ff       <= nxt_warn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State word and drive outputs
  always_comb begin
    pause_mode = (op_mode == drive_pkg::MODE_PROFILE_POS) ||
                 (op_mode == drive_pkg::MODE_VELOCITY) ||
                 (op_mode == drive_pkg::MODE_PROFILE_VEL) ||
                 (op_mode == drive_pkg::MODE_PROFILE_TRQ) ||
                 (op_mode == drive_pkg::MODE_INTERP_POS);
    nxt_pause  = command_ff[drive_pkg::CMD_PAUSE] & pause_mode;
    nxt_status = 16'h0000;
    case (state_ff)
      drive_pkg::S_INHIBITED: begin
        nxt_status[drive_pkg::ST_INHIBIT] = 1'b1;
      end
      drive_pkg::S_READY: begin
        nxt_status[drive_pkg::ST_READY]      = 1'b1;
        nxt_status[drive_pkg::ST_QUICK_STOP] = 1'b1;
        nxt_status[drive_pkg::ST_POWER]      = 1'b1;
      end
      drive_pkg::S_SWITCHED_ON: begin
        nxt_status[drive_pkg::ST_READY]      = 1'b1;
        nxt_status[drive_pkg::ST_SWITCHED]   = 1'b1;
        nxt_status[drive_pkg::ST_QUICK_STOP] = 1'b1;
        nxt_status[drive_pkg::ST_POWER]      = 1'b1;
      end
      drive_pkg::S_RUNNING: begin
        nxt_status[drive_pkg::ST_READY]      = 1'b1;
        nxt_status[drive_pkg::ST_SWITCHED]   = 1'b1;
        nxt_status[drive_pkg::ST_RUNNING]    = 1'b1;
        nxt_status[drive_pkg::ST_QUICK_STOP] = 1'b1;
        nxt_status[drive_pkg::ST_POWER]      = 1'b1;
        nxt_status[drive_pkg::ST_LOOP]       = sense.loop_closed;
      end
      drive_pkg::S_QUICK_STOP: begin
        nxt_status[drive_pkg::ST_READY]    = 1'b1;
        nxt_status[drive_pkg::ST_SWITCHED] = 1'b1;
        nxt_status[drive_pkg::ST_RUNNING]  = 1'b1;
        nxt_status[drive_pkg::ST_POWER]    = 1'b1;
      end
      drive_pkg::S_FAULT_REACT: begin
        nxt_status[3:0] = 4'hF;
      end
      drive_pkg::S_FAULT: begin
        nxt_status[drive_pkg::ST_FAULT] = 1'b1;
      end
      default: nxt_status = 16'h0000;
    endcase
    nxt_status[drive_pkg::ST_WARNING]               = warn_ff;
    nxt_status[drive_pkg::ST_LOCKSTEP]              = sense.in_sync;
    nxt_status[drive_pkg::ST_REMOTE]                = 1'b1;
    nxt_status[drive_pkg::ST_GOAL]                  = sense.goal;
    nxt_status[drive_pkg::ST_LIMIT]                 = limited;
    nxt_status[drive_pkg::ST_MODE_HI:drive_pkg::ST_MODE_LO] = mode_status;
    nxt_power   = (state_ff == drive_pkg::S_SWITCHED_ON) ||
                  (state_ff == drive_pkg::S_RUNNING) ||
                  (state_ff == drive_pkg::S_QUICK_STOP);
    nxt_run     = (state_ff == drive_pkg::S_RUNNING);
    nxt_qs_ramp = (state_ff == drive_pkg::S_QUICK_STOP) ||
                  (state_ff == drive_pkg::S_FAULT_REACT);
    nxt_demand  = (nxt_run && !nxt_pause) ? bounded : 16'h0000;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_ff    <= drive_pkg::STATUS_RESET;
      error_ff     <= drive_pkg::ERROR_RESET;
      power_ff     <= 1'b0;
      run_ff       <= 1'b0;
      qs_ramp_ff   <= 1'b0;
      pause_ff     <= 1'b0;
      mode_bits_ff <= 4'h0;
      demand_ff    <= 16'h0000;
    end else begin
      status_ff    <= nxt_status;
      error_ff     <= error_history_entry[15:0];
      power_ff     <= nxt_power;
      run_ff       <= nxt_run;
      qs_ramp_ff   <= nxt_qs_ramp;
      pause_ff     <= nxt_pause;
      mode_bits_ff <= {command_ff[drive_pkg::CMD_MODE_HI],
                       command_ff[drive_pkg::CMD_MODE_MID:drive_pkg::CMD_MODE_LO]};
      demand_ff    <= nxt_demand;
    end
  end

  assign obj_resp           = resp_ff;
  assign drive_status       = status_ff;
  assign power_stage_on     = power_ff;
  assign run_enabled        = run_ff;
  assign quick_stop_ramp    = qs_ramp_ff;
  assign pause_motion       = pause_ff;
  assign mode_specific_bits = mode_bits_ff;
  assign speed_demand       = demand_ff;

endmodule

// ### src/drive_pkg.sv
// Shared constants, states and carriers of the drive power state control
package drive_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Object indices and subindices
  localparam logic [15:0] IDX_DEVICE_ID  = 16'h4041;
  localparam logic [15:0] IDX_BOOT_INFO  = 16'h4042;
  localparam logic [15:0] IDX_LAST_ERROR = 16'h603F;
  localparam logic [15:0] IDX_COMMAND    = 16'h6040;
  localparam logic [15:0] IDX_STATE_WORD = 16'h6041;
  localparam logic [15:0] IDX_SPEED      = 16'h6042;
  localparam logic [15:0] IDX_SPEED_LIM  = 16'h6046;

  localparam logic [7:0]  SUB_COUNT      = 8'h00;
  localparam logic [7:0]  SUB_BOOT_VER   = 8'h01;
  localparam logic [7:0]  SUB_BOOT_BUS   = 8'h02;
  localparam logic [7:0]  SUB_BOOT_HW    = 8'h03;
  localparam logic [7:0]  SUB_SPEED_MIN  = 8'h01;
  localparam logic [7:0]  SUB_SPEED_MAX  = 8'h02;

  localparam logic [31:0] BOOT_ENTRIES   = 32'h00000003;
  localparam logic [31:0] LIM_ENTRIES    = 32'h00000002;

  ////////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [15:0] COMMAND_RESET  = 16'h0000;
  localparam logic [15:0] STATUS_RESET   = 16'h0000;
  localparam logic [15:0] ERROR_RESET    = 16'h0000;
  localparam logic [15:0] SPEED_RESET    = 16'h00C8;
  localparam logic [31:0] SPEED_MIN_RST  = 32'h00000000;
  localparam logic [31:0] SPEED_MAX_RST  = 32'h00007530;

  ////////////////////////////////////////////////////////////////////////////////
  // Command word bit positions
  localparam int CMD_SWITCH_ON   = 0;
  localparam int CMD_POWER       = 1;
  localparam int CMD_QUICK_STOP  = 2;
  localparam int CMD_RUN         = 3;
  localparam int CMD_MODE_LO     = 4;
  localparam int CMD_MODE_MID    = 6;
  localparam int CMD_FAULT_CLEAR = 7;
  localparam int CMD_PAUSE       = 8;
  localparam int CMD_MODE_HI     = 9;

  // State word bit positions
  localparam int ST_READY        = 0;
  localparam int ST_SWITCHED     = 1;
  localparam int ST_RUNNING      = 2;
  localparam int ST_FAULT        = 3;
  localparam int ST_POWER        = 4;
  localparam int ST_QUICK_STOP   = 5;
  localparam int ST_INHIBIT      = 6;
  localparam int ST_WARNING      = 7;
  localparam int ST_LOCKSTEP     = 8;
  localparam int ST_REMOTE       = 9;
  localparam int ST_GOAL         = 10;
  localparam int ST_LIMIT        = 11;
  localparam int ST_MODE_LO      = 12;
  localparam int ST_MODE_HI      = 13;
  localparam int ST_LOOP         = 15;

  // Operating mode codes in which a pause is honoured
  localparam logic [7:0] MODE_PROFILE_POS = 8'h01;
  localparam logic [7:0] MODE_VELOCITY    = 8'h02;
  localparam logic [7:0] MODE_PROFILE_VEL = 8'h03;
  localparam logic [7:0] MODE_PROFILE_TRQ = 8'h04;
  localparam logic [7:0] MODE_INTERP_POS  = 8'h07;

  ////////////////////////////////////////////////////////////////////////////////
  // Power states, Gray coded along the usual path
  typedef enum logic [2:0] {
    S_NOT_READY   = 3'h0,
    S_INHIBITED   = 3'h1,
    S_READY       = 3'h3,
    S_SWITCHED_ON = 3'h2,
    S_RUNNING     = 3'h6,
    S_QUICK_STOP  = 3'h7,
    S_FAULT_REACT = 3'h5,
    S_FAULT       = 3'h4
  } drive_state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } obj_req_t;

  typedef struct packed {
    logic        valid;
    logic        abort;
    logic [31:0] rdata;
  } obj_resp_t;

  typedef struct packed {
    logic fault;
    logic warning;
    logic goal;
    logic in_sync;
    logic loop_closed;
    logic standstill;
  } sense_t;

endpackage

// ### src/sense_sync.sv
// Three-stage synchroniser with agreement filter for outside inputs
`timescale 1ns/1ns
module sense_sync #(
  parameter int W = 6
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] clean
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] clean_ff;
  logic [W-1:0] nxt_clean;

  // A bit changes only once the second and third stages agree
  always_comb begin
    nxt_clean = clean_ff;
    for (int i = 0; i < W; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_clean[i] = s3_ff[i];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_ff    <= '0;
      s2_ff    <= '0;
      s3_ff    <= '0;
      clean_ff <= '0;
    end else begin
      s1_ff    <= raw;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      clean_ff <= nxt_clean;
    end
  end

  assign clean = clean_ff;

endmodule

// ### src/speed_limiter.sv
// Magnitude clamp of the requested speed against the minimum and maximum
`timescale 1ns/1ns
module speed_limiter (
  input  wire logic [15:0] requested,
  input  wire logic [31:0] min_amount,
  input  wire logic [31:0] max_amount,
  output logic      [15:0] bounded,
  output logic             limited
);

  logic [16:0] ext;
  logic [16:0] mag;
  logic [31:0] mag32;
  logic [15:0] bound;

  // The sign is kept; a bound above 16 bits is cut to its low half
  always_comb begin
    ext     = {requested[15], requested};
    mag     = requested[15] ? (17'h00000 - ext) : ext;
    mag32   = {15'h0000, mag};
    bound   = mag[15:0];
    limited = 1'b0;
    if (mag32 < min_amount) begin
      bound   = min_amount[15:0];
      limited = 1'b1;
    end else if (mag32 > max_amount) begin
      bound   = max_amount[15:0];
      limited = 1'b1;
    end
    bounded = requested[15] ? (16'h0000 - bound) : bound;
  end

endmodule

// ### sim/drive_power_state_control_asserts.sv
// Port checker of the drive power state control
`timescale 1ns/1ns
module drive_power_state_control_asserts (
  input wire logic                 clk,
  input wire logic                 reset,
  input wire drive_pkg::obj_req_t  obj_req,
  input wire drive_pkg::obj_resp_t obj_resp,
  input wire logic [7:0]           op_mode,
  input wire logic                 pause_motion,
  input wire logic                 run_enabled,
  input wire logic [15:0]          speed_demand,
  input wire logic [15:0]          drive_status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_resp_follows_req: assert property (obj_req.valid |=> obj_resp.valid)
    else $error("request without answer");
  a_resp_has_cause: assert property (obj_resp.valid |-> $past(obj_req.valid))
    else $error("answer without request");
  a_refusal_zero: assert property (obj_resp.abort |-> obj_resp.valid && obj_resp.rdata == '0)
    else $error("refusal carries data");
  a_remote_high: assert property (!$past(reset) |-> drive_status[9])
    else $error("bus controlled flag low");
  a_loop_in_run: assert property (drive_status[15] |-> (drive_status & 16'h006F) == 16'h0027)
    else $error("closed loop flag outside running");
  a_inhibit_clear: assert property (drive_status[6] |-> drive_status[3:0] == 4'h0)
    else $error("inhibited flag with other state bits");
  a_fault_pattern: assert property (drive_status[3] |->
    drive_status[2:0] inside {3'h0, 3'h7} && !drive_status[6])
    else $error("fault pattern wrong");
  a_pause_mode: assert property (pause_motion |->
    $past(op_mode) inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h07})
    else $error("pause in wrong mode");
  a_speed_idle: assert property (speed_demand != 16'h0000 |-> run_enabled && !pause_motion)
    else $error("speed demand while not running");
endmodule

bind drive_power_state_control drive_power_state_control_asserts drive_power_state_control_asserts_i (
  .clk(clk), .reset(reset), .obj_req(obj_req), .obj_resp(obj_resp), .op_mode(op_mode),
  .pause_motion(pause_motion), .run_enabled(run_enabled), .speed_demand(speed_demand),
  .drive_status(drive_status));

// ### sim/motion_plant_model.sv
// Mechanics behind the drive: comes to standstill after a braking ramp
`timescale 1ns/1ns
module motion_plant_model (
  input  wire logic         clk,
  input  wire logic         ramp,
  input  wire logic         fault_req,
  input  wire logic         warn_req,
  input  wire logic         sync_lost,
  output drive_pkg::sense_t sense
);
  logic [5:0] ramp_cnt_ff;

  // Standstill only after thirty cycles of braking, so slow stops are exercised
  always_ff @(posedge clk) begin
    ramp_cnt_ff <= ramp ? ramp_cnt_ff + {5'h00, ramp_cnt_ff != 6'h3F} : 6'h00;
  end
  assign sense = '{fault: fault_req, warning: warn_req, goal: 1'b1, in_sync: ~sync_lost,
                   loop_closed: 1'b1, standstill: ramp_cnt_ff >= 6'h1E};
endmodule

// ### sim/drive_power_state_control_tb.sv
// Self-checking bench of the drive power state control
`timescale 1ns/1ns
module drive_power_state_control_tb;
  localparam logic [31:0] ID_VAL = 32'h0000_1357; // Arbitrary value
  logic                 clk       = 1'b0;
  logic                 reset     = 1'b1;
  drive_pkg::obj_req_t  obj_req   = '0;
  drive_pkg::obj_resp_t obj_resp;
  drive_pkg::sense_t    sense_raw;
  logic [7:0]           op_mode   = 8'h00;
  logic                 fault_req = 1'b0;
  logic                 warn_req  = 1'b0;
  logic                 sync_lost = 1'b0;
  logic                 pwr, run, qsr, pause, ab;
  logic [3:0]           msb;
  logic [15:0]          speed, status;
  logic [31:0]          rd;
  int                   error_cnt = 0, n_checks = 0, cyc = 0;
  logic [15:0] ri [7] = '{16'h6040, 16'h6042, 16'h4042, 16'h4042, 16'h4042, 16'h603F, 16'h4041};
  logic [7:0]  rs [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00};
  logic [31:0] re [7] = '{32'h0, 32'hC8, 32'h3, 32'h0004_0002, 32'h2, 32'h5678, ID_VAL};
  logic [15:0] wi [4] = '{16'h4041, 16'h4042, 16'h603F, 16'h6041};

  drive_power_state_control #(.DEVICE_ID(ID_VAL), .BOOT_VERSION(32'h0004_0002),
    .BOOT_BUS_MASK(32'h0000_0002)) drive_power_state_control_i (
    .clk(clk), .reset(reset), .obj_req(obj_req), .obj_resp(obj_resp), .sense_raw(sense_raw),
    .op_mode(op_mode), .mode_status(2'b00), .error_history_entry(32'h1234_5678),
    .power_stage_on(pwr), .run_enabled(run), .quick_stop_ramp(qsr), .pause_motion(pause),
    .mode_specific_bits(msb), .speed_demand(speed), .drive_status(status));
  motion_plant_model motion_plant_model_i (.clk(clk), .ramp(qsr), .fault_req(fault_req),
    .warn_req(warn_req), .sync_lost(sync_lost), .sense(sense_raw));

  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One object access; request held through its taking edge
  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
    @(negedge clk);
    obj_req = '{1'b1, w, i, s, d};
    @(negedge clk);
    obj_req.valid = 1'b0;
    rd = obj_resp.rdata;
    ab = obj_resp.abort;
    chk({31'h0, obj_resp.valid}, 32'h1);
  endtask

  // Polls the state word until the masked value appears, bounded
  task automatic wait_st(input logic [15:0] m, input logic [15:0] e);
    for (int i = 0; i < 40; i++) begin
      acc(1'b0, 16'h6041, 8'h00, 32'h0);
      if ((rd[15:0] & m) === e) break;
    end
    chk({16'h0, rd[15:0] & m}, {16'h0, e});
  endtask

  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    for (int i = 0; i < 7; i++) begin
      acc(1'b0, ri[i], rs[i], 32'h0);
      chk(rd, re[i]);
    end
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, wi[i], (i == 1) ? 8'h01 : 8'h00, 32'hFFFF);
      chk({31'h0, ab}, 32'h1);
      chk(rd, 32'h0);
    end
    wait_st(16'h004F, 16'h0040);
    acc(1'b1, 16'h6040, 8'h00, 32'h6);
    wait_st(16'h006F, 16'h0021);
    acc(1'b1, 16'h6040, 8'h00, 32'h7);
    wait_st(16'h006F, 16'h0023);
    acc(1'b1, 16'h6042, 8'h00, 32'hFF00);
    acc(1'b0, 16'h6042, 8'h00, 32'h0);
    chk(rd, 32'hFFFF_FF00);
    acc(1'b1, 16'h6040, 8'h00, 32'h25F);
    wait_st(16'h836F, 16'h8327);
    chk({26'h0, pwr, run, msb}, {26'h0, 6'h3D});
    chk({16'h0, speed}, 32'hFF00);
    acc(1'b1, 16'h6046, 8'h02, 32'h80);
    wait_st(16'h0800, 16'h0800);
    chk({16'h0, speed}, 32'hFF80);
    op_mode = 8'h02;
    acc(1'b1, 16'h6040, 8'h00, 32'h15F);
    acc(1'b0, 16'h6041, 8'h00, 32'h0);
    chk({15'h0, pause, speed}, {15'h0, 1'b1, 16'h0});
    op_mode = 8'h05;
    acc(1'b0, 16'h6041, 8'h00, 32'h0);
    acc(1'b0, 16'h6041, 8'h00, 32'h0);
    chk({31'h0, pause}, 32'h0);
    acc(1'b1, 16'h6040, 8'h00, 32'hB);
    wait_st(16'h006F, 16'h0007);
    wait_st(16'h004F, 16'h0040);
    acc(1'b1, 16'h6040, 8'h00, 32'h6);
    wait_st(16'h006F, 16'h0021);
    fault_req = 1'b1;
    wait_st(16'h004F, 16'h000F);
    wait_st(16'h004F, 16'h0008);
    acc(1'b1, 16'h6040, 8'h00, 32'h80);
    repeat (4) @(negedge clk);
    chk({16'h0, status & 16'h004F}, 32'h8);
    fault_req = 1'b0;
    repeat (10) @(negedge clk);
    acc(1'b1, 16'h6040, 8'h00, 32'h0);
    acc(1'b1, 16'h6040, 8'h00, 32'h80);
    wait_st(16'h004F, 16'h0040);
    // Warning latches past its input; lockstep flag follows the link
    warn_req  = 1'b1;
    sync_lost = 1'b1;
    wait_st(16'h0180, 16'h0080);
    warn_req  = 1'b0;
    sync_lost = 1'b0;
    repeat (10) @(negedge clk);
    wait_st(16'h0180, 16'h0180);
    acc(1'b1, 16'h6040, 8'h00, 32'h0);
    acc(1'b1, 16'h6040, 8'h00, 32'h80);
    wait_st(16'h0080, 16'h0000);
    give_verdict();
  end
endmodule
